// [hw/smtc_pkg.sv]
// Constants, field layouts and types for the SPI master timing block.
// Assumes one 20 MHz bus clock and a configuration held outside.
//
// Contract
// - Global control bit 0 enables master drive
// - Format bit 16 selects clock phase
// - Format bit 17 sets clock idle polarity
// - Prescale bits 15:8 give value+1 clocks period
// - Prescale zero gives two-clock period
// - Serial clock spends half period each level, active level one clock less if period odd
// - Phase 1 launches data half period before capture
// - Phase 1 setup: half period plus delay+2/+3
// - Select held delay+1 clocks after last edge
// - Both select delays come from delay register

package smtc_pkg;

    localparam int MASTER_BIT      = 0;
    localparam int PHASE_BIT       = 16;
    localparam int POLARITY_BIT    = 17;
    localparam int PRESCALE_LSB    = 8;
    localparam int PRESCALE_MSB    = 15;

    localparam int CLK_PERIOD_NS   = 50;
    localparam int MIN_SCLK_NS     = 25;
    localparam int MIN_SCLK_CYC    = (MIN_SCLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1
                                     ? 1 : (MIN_SCLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int SETUP_BASE      = 2;
    localparam int HOLD_OPT_EXTRA  = 1;
    localparam int DESELECT_BASE   = 1;
    localparam int PS_ZERO_PERIOD  = 2;
    localparam int CNT_W           = 10;

    localparam logic RST_SELECT_N  = 1'b1;
    localparam logic RST_SCLK      = 1'b0;
    localparam logic RST_MOSI      = 1'b0;

    typedef struct packed {
        logic [13:0] reserved;
        logic        clock_polarity;
        logic        clock_phase;
        logic [7:0]  clock_prescale_value;
        logic [7:0]  char_len_unused;
    } smtc_fmt_s;

    typedef struct packed {
        logic [7:0] clock_to_deselect_delay;
        logic [7:0] select_to_clock_delay;
    } smtc_dly_s;

    typedef enum logic [1:0] {
        SMTC_IDLE,
        SMTC_SETUP,
        SMTC_SHIFT,
        SMTC_HOLD
    } smtc_state_e;

endpackage

// [hw/smtc_top.sv]
// SPI master serial clock, data shift and chip select timing.
// Assumes configuration ports are static while a word is in flight.
`timescale 1ns/10ps
`default_nettype none

module smtc_top #(
    parameter int WORD_BITS = 16
) (
    input  wire logic                    CLK,
    input  wire logic                    RST,
    input  wire logic [31:0]             PORT_GLOBAL_CONTROL_REG,
    input  wire smtc_pkg::smtc_fmt_s     PORT_FORMAT_REG,
    input  wire smtc_pkg::smtc_dly_s     SELECT_DELAY_REG,
    input  wire logic                    SELECT_HOLD_OPTION,
    input  wire logic                    START,
    input  wire logic [WORD_BITS-1:0]    TX_DATA,
    input  wire logic                    MASTER_IN_LINE,
    output logic                         SERIAL_CLOCK_PIN,
    output logic                         SERIAL_CLOCK_PIN_OE,
    output logic                         MASTER_OUT_LINE,
    output logic                         MASTER_OUT_LINE_OE,
    output logic                         SELECT_N,
    output logic                         BUSY,
    output logic                         DONE,
    output logic [WORD_BITS-1:0]         RX_DATA
);

    localparam int CW = smtc_pkg::CNT_W;
    localparam int EW = $clog2(2 * WORD_BITS);
    localparam logic [EW-1:0] LAST_EDGE = EW'(2 * WORD_BITS - 1);

    function automatic logic [8:0] calc_period(input logic [7:0] ps);
        calc_period = (ps == 8'h00) ? 9'(smtc_pkg::PS_ZERO_PERIOD) : {1'b0, ps} + 9'h001;
    endfunction

    smtc_pkg::smtc_state_e state;
    smtc_pkg::smtc_state_e next_state;
    smtc_pkg::smtc_fmt_s   cfg_fmt;
    smtc_pkg::smtc_dly_s   cfg_dly;
    logic                  cfg_hold;
    logic [CW-1:0]         cnt;
    logic [EW-1:0]         ecnt;
    logic                  sclk_act;
    logic [WORD_BITS-1:0]  tx;
    logic [WORD_BITS-1:0]  rx;
    logic                  oe;

    // In idle the live settings are used, so a start sees them at once
    wire                       idle      = (state == smtc_pkg::SMTC_IDLE);
    wire smtc_pkg::smtc_fmt_s  fmt_src   = idle ? PORT_FORMAT_REG : cfg_fmt;
    wire smtc_pkg::smtc_dly_s  dly_src   = idle ? SELECT_DELAY_REG : cfg_dly;
    wire                       hold_src  = idle ? SELECT_HOLD_OPTION : cfg_hold;
    wire                       master_en = PORT_GLOBAL_CONTROL_REG[smtc_pkg::MASTER_BIT];
    wire                       pha       = fmt_src.clock_phase;
    wire                       pol       = fmt_src.clock_polarity;

    // Period from prescale; odd periods give the active half one clock less
    wire [8:0]     period    = calc_period(fmt_src.clock_prescale_value);
    wire [7:0]     half_hi   = period[8:1];
    wire [8:0]     half_lo   = period - {1'b0, half_hi};
    wire           extra     = hold_src & (~pha | pol);
    wire [CW-1:0]  setup_need = CW'(dly_src.select_to_clock_delay)
                              + CW'(smtc_pkg::SETUP_BASE)
                              + CW'(extra)
                              + (pha ? CW'(half_hi) : CW'(0));

    wire start_ok  = idle & START & master_en;
    wire tick      = (cnt == '0);
    wire edge_now  = tick & ((state == smtc_pkg::SMTC_SETUP) | (state == smtc_pkg::SMTC_SHIFT));
    wire lead_now  = edge_now & ~sclk_act;
    wire trail_now = edge_now & sclk_act;
    wire last_now  = trail_now & (ecnt == LAST_EDGE);
    wire end_now   = (state == smtc_pkg::SMTC_HOLD) & tick;

    // Phase 1 launches on the leading edge, phase 0 on each trailing edge but the last
    wire launch_now  = pha ? lead_now : (trail_now & ~last_now);
    wire capture_now = pha ? trail_now : lead_now;

    assign next_state = !master_en                   ? smtc_pkg::SMTC_IDLE :
                        start_ok                     ? smtc_pkg::SMTC_SETUP :
                        (state == smtc_pkg::SMTC_SETUP && tick) ? smtc_pkg::SMTC_SHIFT :
                        last_now                     ? smtc_pkg::SMTC_HOLD :
                        end_now                      ? smtc_pkg::SMTC_IDLE :
                        state;

    // Every delay is a whole count of bus clocks on one counter
    wire [CW-1:0] next_cnt = start_ok                 ? setup_need - CW'(1) :
                             !tick                    ? cnt - CW'(1) :
                             last_now                 ? CW'(dly_src.clock_to_deselect_delay) :
                             lead_now                 ? CW'(half_hi) - CW'(1) :
                             trail_now                ? CW'(half_lo) - CW'(1) :
                             '0;

    wire [WORD_BITS-1:0] next_tx = start_ok   ? (pha ? TX_DATA : TX_DATA << 1) :
                                   launch_now ? tx << 1 :
                                   tx;

    always_ff @(posedge CLK) begin
        if (RST) begin
            state    <= smtc_pkg::SMTC_IDLE;
            cnt      <= '0;
            ecnt     <= '0;
            cfg_fmt  <= '0;
            cfg_dly  <= '0;
            cfg_hold <= 1'b0;
            oe       <= 1'b0;
        end else begin
            state    <= next_state;
            cnt      <= next_state == smtc_pkg::SMTC_IDLE ? '0 : next_cnt;
            ecnt     <= start_ok ? '0 : edge_now ? ecnt + EW'(1) : ecnt;
            cfg_fmt  <= fmt_src;
            cfg_dly  <= dly_src;
            cfg_hold <= hold_src;
            oe       <= master_en;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            sclk_act        <= smtc_pkg::RST_SCLK;
            SERIAL_CLOCK_PIN <= smtc_pkg::RST_SCLK;
        end else begin
            // Toggle only on edges; an abort returns straight to idle level
            sclk_act         <= master_en & (edge_now ? ~sclk_act : sclk_act & ~idle);
            SERIAL_CLOCK_PIN <= (master_en & (edge_now ? ~sclk_act : sclk_act & ~idle)) ^ pol;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            tx              <= '0;
            rx              <= '0;
            MASTER_OUT_LINE <= smtc_pkg::RST_MOSI;
        end else begin
            tx <= next_tx;
            if (capture_now) begin
                rx <= {rx[WORD_BITS-2:0], MASTER_IN_LINE};
            end
            if (start_ok && !pha) begin
                MASTER_OUT_LINE <= TX_DATA[WORD_BITS-1];
            end else if (launch_now) begin
                MASTER_OUT_LINE <= tx[WORD_BITS-1];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            SELECT_N <= smtc_pkg::RST_SELECT_N;
            DONE     <= 1'b0;
            RX_DATA  <= '0;
        end else begin
            // Select falls with the start and rises one clock after hold expiry
            SELECT_N <= (next_state == smtc_pkg::SMTC_IDLE);
            DONE     <= end_now & master_en;
            if (end_now) begin
                RX_DATA <= rx;
            end
        end
    end

    assign BUSY                = ~idle;
    assign SERIAL_CLOCK_PIN_OE = oe;
    assign MASTER_OUT_LINE_OE  = oe;

    // Helper counters read only by the checks below
    logic [CW-1:0] since_cs;
    logic [CW-1:0] since_edge;
    logic [CW-1:0] last_half;
    logic [CW-1:0] since_launch;
    logic [CW-1:0] since_last;

    always_ff @(posedge CLK) begin
        if (RST) begin
            since_cs     <= '0;
            since_edge   <= '0;
            last_half    <= '0;
            since_launch <= '0;
            since_last   <= '0;
        end else begin
            since_cs     <= start_ok ? '0 : since_cs + CW'(1);
            since_edge   <= edge_now ? '0 : since_edge + CW'(1);
            last_half    <= edge_now ? since_edge : last_half;
            since_launch <= launch_now ? '0 : since_launch + CW'(1);
            since_last   <= last_now ? '0 : since_last + CW'(1);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_master_off_quiet: assert property (
        !master_en |=> !SERIAL_CLOCK_PIN_OE && !MASTER_OUT_LINE_OE && SELECT_N && !BUSY)
        else $error("pins driven or select active with master mode off");

    chk_phase0_first_bit: assert property (
        start_ok && !PORT_FORMAT_REG.clock_phase |=>
            MASTER_OUT_LINE == $past(TX_DATA[WORD_BITS-1]) && !SELECT_N)
        else $error("phase 0 first bit not presented with select");

    chk_idle_clock_level: assert property (
        idle && $stable(cfg_fmt.clock_polarity) ##1 idle |-> SERIAL_CLOCK_PIN == cfg_fmt.clock_polarity)
        else $error("serial clock idle level does not follow polarity");

    chk_period_sum: assert property (
        lead_now && state == smtc_pkg::SMTC_SHIFT |->
            9'(last_half + since_edge + CW'(2)) == calc_period(cfg_fmt.clock_prescale_value)
            && calc_period(cfg_fmt.clock_prescale_value) >= 9'(smtc_pkg::MIN_SCLK_CYC))
        else $error("serial clock period differs from prescale plus one");

    chk_zero_prescale: assert property (
        edge_now && state == smtc_pkg::SMTC_SHIFT && cfg_fmt.clock_prescale_value == 8'h00
            |-> since_edge == '0)
        else $error("prescale zero does not give a two-clock period");

    chk_half_levels: assert property (
        edge_now && state == smtc_pkg::SMTC_SHIFT |->
            since_edge == (sclk_act ? CW'(half_hi) : CW'(half_lo)) - CW'(1))
        else $error("serial clock half period has wrong length");

    chk_phase1_launch: assert property (
        pha && trail_now |-> since_launch == CW'(half_hi) - CW'(1) ##1 $stable(MASTER_OUT_LINE))
        else $error("phase 1 data not launched half a period before capture");

    chk_setup_delay: assert property (
        state == smtc_pkg::SMTC_SETUP && tick |-> since_cs ==
            CW'(cfg_dly.select_to_clock_delay) + CW'(1) + CW'(cfg_hold & (~pha | pol))
            + (pha ? CW'(half_hi) : CW'(0)))
        else $error("select to first clock edge delay wrong");

    chk_hold_delay: assert property (
        end_now && master_en |-> since_last == CW'(cfg_dly.clock_to_deselect_delay) ##1 SELECT_N)
        else $error("select not held delay plus one clocks after last edge");

    // Drive enable lags master enable by one clock, never more
    chk_enable_follows: assert property (
        master_en |=> SERIAL_CLOCK_PIN_OE && MASTER_OUT_LINE_OE)
        else $error("pins not driven one clock after master enable");

    // A start while disabled must leave no trace on select
    chk_start_refused: assert property (
        idle && START && !master_en |=> SELECT_N && !BUSY)
        else $error("start taken while master mode off");

    // Select may only fall on an accepted start
    chk_select_fall: assert property (
        $fell(SELECT_N) |-> $past(start_ok))
        else $error("select fell without an accepted start");

    // Select low always means a word is in flight
    chk_select_busy: assert property (
        !SELECT_N |-> BUSY)
        else $error("select active while idle");

    // No clock edge may appear inside the deselect hold time
    chk_hold_quiet: assert property (
        state == smtc_pkg::SMTC_HOLD && !end_now |=> $stable(SERIAL_CLOCK_PIN))
        else $error("serial clock moved during select hold");

    // Done is a single-cycle pulse
    chk_done_pulse: assert property (
        DONE |=> !DONE)
        else $error("done held for more than one clock");

    // Phase 1 holds its data until the first leading edge leaves setup
    chk_phase1_setup_quiet: assert property (
        state == smtc_pkg::SMTC_SETUP && !tick && pha |=> $stable(MASTER_OUT_LINE))
        else $error("phase 1 data moved before the first clock edge");

    // Clock stays at its idle level while select is released
    chk_clock_outside_frame: assert property (
        SELECT_N && $past(SELECT_N) && idle && $past(idle) && $stable(cfg_fmt.clock_polarity)
            |-> SERIAL_CLOCK_PIN == cfg_fmt.clock_polarity)
        else $error("serial clock toggled outside a frame");

endmodule

`default_nettype wire

// [dv/smtc_slave_model.sv]
// Behavioural SPI slave on the far side of the master timing block.
// Assumes the mode inputs stay still while select is low.
`timescale 1ns/10ps
`default_nettype none
module smtc_slave_model #(
    parameter int WORD_BITS = 16
) (
    input  wire logic                 sclk,
    input  wire logic                 sel_n,
    input  wire logic                 mosi,
    input  wire logic                 pol,
    input  wire logic                 pha,
    input  wire logic [WORD_BITS-1:0] tx_word,
    output logic                      miso,
    output logic [WORD_BITS-1:0]      rx_word
);
    logic [WORD_BITS-1:0] sh;
    initial begin
        miso = 1'b0;
        rx_word = '0;
        sh = '0;
    end
    // No pull on the line, so a released line must not keep its last bit
    always @(posedge sel_n) begin
        miso = ~miso;
    end
    always @(negedge sel_n) begin
        rx_word = '0;
        sh = tx_word;
        if (!pha) begin
            miso = sh[WORD_BITS-1];
            sh = sh << 1;
        end else begin
            miso = ~miso;
        end
    end
    // Leading edge leaves the idle level; phase picks capture or launch
    always @(sclk) begin
        if (!sel_n) begin
            if ((sclk != pol) != pha) begin
                rx_word = {rx_word[WORD_BITS-2:0], mosi};
            end else begin
                miso = sh[WORD_BITS-1];
                sh = sh << 1;
            end
        end
    end
endmodule
`default_nettype wire

// [dv/test_spi_master_timing_control.sv]
// Self-checking bench for the SPI master timing block.
// Assumes smtc_pkg, smtc_top and the slave model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_spi_master_timing_control;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic [31:0]         gcr = 32'h0000_0001;
    smtc_pkg::smtc_fmt_s fmt = '0;
    smtc_pkg::smtc_dly_s dly = '0;
    logic                hold = 1'b0;
    logic                start = 1'b0;
    logic [15:0]         tx = 16'h0000;
    logic [15:0]         sw = 16'h0000;
    logic                miso, sclk, sclk_oe, mosi, mosi_oe, sel_n, busy, done;
    logic [15:0]         rx, srx;
    int                  fails = 0;
    int                  total_checks = 0;

    always #25 clk = ~clk;

    smtc_top #(.WORD_BITS(16)) i_dut (.CLK(clk), .RST(rst), .PORT_GLOBAL_CONTROL_REG(gcr),
        .PORT_FORMAT_REG(fmt), .SELECT_DELAY_REG(dly), .SELECT_HOLD_OPTION(hold),
        .START(start), .TX_DATA(tx), .MASTER_IN_LINE(miso), .SERIAL_CLOCK_PIN(sclk),
        .SERIAL_CLOCK_PIN_OE(sclk_oe), .MASTER_OUT_LINE(mosi), .MASTER_OUT_LINE_OE(mosi_oe),
        .SELECT_N(sel_n), .BUSY(busy), .DONE(done), .RX_DATA(rx));

    smtc_slave_model #(.WORD_BITS(16)) i_slave (.sclk(sclk), .sel_n(sel_n), .mosi(mosi),
        .pol(fmt.clock_polarity), .pha(fmt.clock_phase), .tx_word(sw), .miso(miso),
        .rx_word(srx));

    task automatic check(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic run_word(input logic [7:0] ps, input logic pha, pol, hd,
                            input logic [7:0] c2t, t2c, input logic [15:0] d, s_d);
        int   p, s, k, last, edges;
        logic prev;
        p = (ps == 8'h00) ? 2 : int'(ps) + 1;
        s = int'(c2t) + 2 + int'(hd & (~pha | pol)) + (pha ? p / 2 : 0);
        @(posedge clk);
        fmt <= '{clock_polarity: pol, clock_phase: pha, clock_prescale_value: ps, default: '0};
        dly <= '{clock_to_deselect_delay: t2c, select_to_clock_delay: c2t};
        hold <= hd;
        sw <= s_d;
        repeat (2) @(posedge clk);
        #1;
        check(sclk === pol, "idle level");
        @(posedge clk);
        start <= 1'b1;
        tx <= d;
        @(posedge clk);
        start <= 1'b0;
        #1;
        k = 1;
        last = 1;
        edges = 0;
        prev = pol;
        check(sel_n === 1'b0 && busy === 1'b1, "select at take");
        while (done !== 1'b1 && k < 9000) begin
            @(posedge clk);
            #1;
            k++;
            if (sclk !== prev) begin
                edges++;
                check(k - last == (edges == 1 ? s : edges % 2 == 0 ? p / 2 : p - p / 2),
                      "edge gap");
                last = k;
                prev = sclk;
            end
        end
        if (k >= 9000) begin
            fails++;
            $display("[ERR] %0t no end of word", $time);
            wrap_up();
        end
        check(sel_n === 1'b1 && busy === 1'b0 && k - last == int'(t2c) + 1, "hold");
        check(edges == 32 && rx === s_d && srx === d, "word data");
        @(posedge clk);
        #1;
        check(done === 1'b0 && sclk === pol && sclk_oe === 1'b1, "after word");
    endtask

    task automatic t_reset_state;
        check(sel_n === 1'b1 && busy === 1'b0 && done === 1'b0 && rx === 16'h0000, "reset");
        repeat (2) @(posedge clk);
        #1;
        check(sclk_oe === 1'b1 && mosi_oe === 1'b1, "drive enable");
    endtask

    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            run_word(8'h01, m[0], m[1], 1'b0, 8'h00, 8'h00, 16'ha5c3 ^ 16'(m), 16'h3c5a);
        end
    endtask

    task automatic t_prescale;
        run_word(8'h00, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 16'h8001, 16'h7ffe);
        run_word(8'h04, 1'b0, 1'b1, 1'b0, 8'h01, 8'h00, 16'h1234, 16'hedcb);
        run_word(8'hff, 1'b1, 1'b1, 1'b0, 8'h00, 8'h01, 16'hf00f, 16'h0ff0);
    endtask

    task automatic t_delays;
        run_word(8'h03, 1'b0, 1'b0, 1'b1, 8'h03, 8'h05, 16'h5555, 16'haaaa);
        run_word(8'h03, 1'b1, 1'b0, 1'b1, 8'h02, 8'h00, 16'hc001, 16'h4002);
        run_word(8'h02, 1'b1, 1'b1, 1'b1, 8'h00, 8'h07, 16'h0f0f, 16'hf0f0);
    endtask

    task automatic t_refused;
        @(posedge clk);
        gcr <= 32'h0000_0000;
        repeat (2) @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check(sel_n === 1'b1 && busy === 1'b0 && sclk_oe === 1'b0, "disabled");
        @(posedge clk);
        gcr <= 32'h0000_0001;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_abort;
        bit seen;
        seen = 1'b0;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (6) @(posedge clk);
        gcr <= 32'h0000_0000;
        @(posedge clk);
        #1;
        check(sel_n === 1'b1 && busy === 1'b0, "abort");
        repeat (40) begin
            @(posedge clk);
            #1;
            seen = seen | (done === 1'b1);
        end
        check(!seen, "done after abort");
        gcr <= 32'h0000_0001;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset_state();
        t_modes();
        t_prescale();
        t_delays();
        t_refused();
        t_abort();
        wrap_up();
    end
endmodule
`default_nettype wire
